// ==== core/ifp_pkg.sv ====
/*
  Shared constants for the input fault, power-good and turn-on command registers:
  command codes, reset values, field positions, limit ranges and timing.
  Assumes a 200 MHz core clock and a PMBus transaction layer in front of the bank.
*/
package ifp_pkg;

  // =====================================================================
  // command codes
  localparam logic [7:0] CMD_OVIN_RESPONSE = 8'h56;
  localparam logic [7:0] CMD_UVIN_WARN = 8'h58;
  localparam logic [7:0] CMD_OCIN_WARN = 8'h5d;
  localparam logic [7:0] CMD_PGOOD_ON = 8'h5e;
  localparam logic [7:0] CMD_PGOOD_OFF = 8'h5f;
  localparam logic [7:0] CMD_TON_WAIT = 8'h60;

  // =====================================================================
  // values loaded at start-up
  localparam logic [7:0] RST_OVIN_RESPONSE = 8'hb8;
  localparam logic [15:0] RST_UVIN_WARN = 16'hf812;
  localparam logic [15:0] RST_OCIN_WARN = 16'hf80a;
  localparam logic [15:0] RST_PGOOD_ON = 16'h0114;
  localparam logic [15:0] RST_PGOOD_OFF = 16'h0105;
  localparam logic [15:0] RST_TON_WAIT = 16'h0000;

  // =====================================================================
  // response byte layout
  localparam int RSP_MSB = 7;
  localparam int RSP_LSB = 6;
  localparam int RTY_MSB = 5;
  localparam int RTY_LSB = 3;
  localparam int DLY_MSB = 2;
  localparam int DLY_LSB = 0;
  localparam logic [1:0] RSP_CONTINUE = 2'h0;
  localparam logic [1:0] RSP_OFF_WHILE = 2'h3;
  localparam logic [7:0] OVIN_VENDOR_CODE = 8'hb8;

  // =====================================================================
  // linear11 word layout and per-command limits
  localparam int MANT_MSB = 10;
  localparam int EXP_LSB = 11;
  localparam int EXP_MSB = 15;
  localparam int FIX_W = 48;
  localparam logic [4:0] EXP_HALF = 5'h1f;
  localparam logic [4:0] EXP_UNIT = 5'h00;
  localparam logic signed [10:0] UVIN_MANT_MIN = 11'sh002;
  localparam logic signed [10:0] UVIN_MANT_MAX = 11'sh0a0;
  localparam logic signed [10:0] OCIN_MANT_MIN = 11'sh000;
  localparam logic signed [10:0] OCIN_MANT_MAX = 11'sh0fe;
  localparam logic signed [10:0] TON_MANT_MIN = 11'sh000;
  localparam logic signed [10:0] TON_MANT_MAX = 11'sh07f;

  // =====================================================================
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int TON_STEP_US = 1000;
  localparam int TON_STEP_CYC = (CLK_HZ / 1_000_000) * TON_STEP_US;

  // =====================================================================
  // state of the overvoltage response machine
  typedef enum logic [2:0] {
    OV_RUN = 3'b001,
    OV_HOLD = 3'b010,
    OV_LATCH = 3'b100
  } ifp_ov_e;

endpackage

// ==== core/ifp_lin11_scale.sv ====
/*
  Converts one LINEAR11 word into a signed fixed-point value with 16 fraction bits.
  Assumes the exponent lies in the full -16..15 range of the format.
*/
`timescale 1ns/1ps
module ifp_lin11_scale (
  input wire logic [15:0] word,
  output logic signed [ifp_pkg::FIX_W-1:0] value
);

  // =====================================================================
  // mantissa times two to the exponent
  wire logic [10:0] mant = word[ifp_pkg::MANT_MSB:0];
  wire logic [4:0] expo = word[ifp_pkg::EXP_MSB:ifp_pkg::EXP_LSB];
  // exponent plus sixteen, taken as an unsigned shift
  wire logic [4:0] shift = {~expo[4], expo[3:0]};
  wire logic signed [ifp_pkg::FIX_W-1:0] mant_ext = {{(ifp_pkg::FIX_W-11){mant[10]}}, mant};

  assign value = mant_ext <<< shift;

endmodule

// ==== core/ifp_ton_timer.sv ====
/*
  Turn-on wait timer: after a start request rises, counts the programmed number of
  milliseconds, then raises done until the request falls.
  Assumes start is a synchronous level; step_cyc sets the cycles of one millisecond.
*/
`timescale 1ns/1ps
module ifp_ton_timer #(
  parameter int STEP_CYC = ifp_pkg::TON_STEP_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [6:0] delay_ms,
  output logic done
);

  // =====================================================================
  // prescaler and millisecond counter
  logic [17:0] pre_ff;
  logic [6:0] ms_ff;
  logic done_ff;

  wire logic pre_wrap = (pre_ff == 18'(STEP_CYC - 1));
  wire logic reached = (ms_ff >= delay_ms);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pre_ff <= 18'h00000;
      ms_ff <= 7'h00;
      done_ff <= 1'b0;
    end else if (ce) begin
      if (!start) begin
        pre_ff <= 18'h00000;
        ms_ff <= 7'h00;
        done_ff <= 1'b0;
      end else if (!done_ff) begin
        done_ff <= reached;
        pre_ff <= pre_wrap ? 18'h00000 : pre_ff + 18'h00001;
        if (pre_wrap && !reached) begin
          ms_ff <= ms_ff + 7'h01;
        end
      end
    end
  end

  assign done = done_ff;

endmodule

// ==== core/ifp_regs.sv ====
/*
  Command register bank for input overvoltage response, input undervoltage and
  overcurrent warnings, power-good thresholds and turn-on wait, with the logic
  that these registers steer.
  Assumes a PMBus transaction layer delivers decoded commands one per cycle at most,
  and that measurements arrive as synchronous words already sampled.
*/
`timescale 1ns/1ps
module ifp_regs #(
  parameter int TON_STEP_CYC = ifp_pkg::TON_STEP_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] iin_meas,
  input wire logic [15:0] vout_meas,
  input wire logic ovin_detect,
  input wire logic clear_faults,
  input wire logic start_request,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic cml_fault,
  output logic vin_low_warn,
  output logic iin_oc_warn,
  output logic pgood,
  output logic out_enable,
  output logic ovin_off,
  output logic ovin_latched,
  output logic vendor_deviation
);

  // =====================================================================
  // registers
  logic [7:0] ovin_resp_ff;
  logic [15:0] uvin_warn_ff;
  logic [15:0] ocin_warn_ff;
  logic [15:0] pg_on_ff;
  logic [15:0] pg_off_ff;
  logic [15:0] ton_wait_ff;

  logic rsp_valid_ff;
  logic [15:0] rsp_rdata_ff;
  logic cml_fault_ff;
  logic vin_low_ff;
  logic iin_oc_ff;
  logic pgood_ff;
  logic out_enable_ff;
  logic ovin_off_ff;
  logic ovin_latched_ff;
  logic vendor_dev_ff;

  ifp_pkg::ifp_ov_e ov_state_ff;
  ifp_pkg::ifp_ov_e nxt_ov_state;

  // =====================================================================
  // command decode
  wire logic hit_resp = (cmd_code == ifp_pkg::CMD_OVIN_RESPONSE);
  wire logic hit_uvin = (cmd_code == ifp_pkg::CMD_UVIN_WARN);
  wire logic hit_ocin = (cmd_code == ifp_pkg::CMD_OCIN_WARN);
  wire logic hit_pgon = (cmd_code == ifp_pkg::CMD_PGOOD_ON);
  wire logic hit_pgoff = (cmd_code == ifp_pkg::CMD_PGOOD_OFF);
  wire logic hit_ton = (cmd_code == ifp_pkg::CMD_TON_WAIT);
  wire logic hit_any = hit_resp | hit_uvin | hit_ocin | hit_pgon | hit_pgoff | hit_ton;

  wire logic do_write = cmd_valid & cmd_write;
  wire logic do_read = cmd_valid & ~cmd_write;

  // =====================================================================
  // linear11 write check, fixed exponent plus mantissa range
  wire logic signed [10:0] wr_mant = $signed(cmd_wdata[ifp_pkg::MANT_MSB:0]);
  wire logic [4:0] wr_exp = cmd_wdata[ifp_pkg::EXP_MSB:ifp_pkg::EXP_LSB];

  // a wrong exponent is a wrong step size
  wire logic uvin_ok = (wr_exp == ifp_pkg::EXP_HALF)
    && (wr_mant >= ifp_pkg::UVIN_MANT_MIN) && (wr_mant <= ifp_pkg::UVIN_MANT_MAX);
  wire logic ocin_ok = (wr_exp == ifp_pkg::EXP_HALF)
    && (wr_mant >= ifp_pkg::OCIN_MANT_MIN) && (wr_mant <= ifp_pkg::OCIN_MANT_MAX);
  wire logic ton_ok = (wr_exp == ifp_pkg::EXP_UNIT)
    && (wr_mant >= ifp_pkg::TON_MANT_MIN) && (wr_mant <= ifp_pkg::TON_MANT_MAX);

  wire logic wr_resp = do_write & hit_resp;
  wire logic wr_uvin = do_write & hit_uvin & uvin_ok;
  wire logic wr_ocin = do_write & hit_ocin & ocin_ok;
  wire logic wr_pgon = do_write & hit_pgon;
  wire logic wr_pgoff = do_write & hit_pgoff;
  wire logic wr_ton = do_write & hit_ton & ton_ok;

  // rejected limit writes and unknown commands both count as comm faults
  wire logic bad_limit = do_write & ((hit_uvin & ~uvin_ok) | (hit_ocin & ~ocin_ok) | (hit_ton & ~ton_ok));
  wire logic nxt_cml = bad_limit | (cmd_valid & ~hit_any);

  // =====================================================================
  // register storage, reset loads the stored defaults
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ovin_resp_ff <= ifp_pkg::RST_OVIN_RESPONSE;
    end else if (ce && wr_resp) begin
      ovin_resp_ff <= cmd_wdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      uvin_warn_ff <= ifp_pkg::RST_UVIN_WARN;
    end else if (ce && wr_uvin) begin
      uvin_warn_ff <= cmd_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ocin_warn_ff <= ifp_pkg::RST_OCIN_WARN;
    end else if (ce && wr_ocin) begin
      ocin_warn_ff <= cmd_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pg_on_ff <= ifp_pkg::RST_PGOOD_ON;
    end else if (ce && wr_pgon) begin
      pg_on_ff <= cmd_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pg_off_ff <= ifp_pkg::RST_PGOOD_OFF;
    end else if (ce && wr_pgoff) begin
      pg_off_ff <= cmd_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ton_wait_ff <= ifp_pkg::RST_TON_WAIT;
    end else if (ce && wr_ton) begin
      ton_wait_ff <= cmd_wdata;
    end
  end

  // =====================================================================
  // read-back mux
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (1'b1)
      hit_resp: rd_mux = {8'h00, ovin_resp_ff};
      hit_uvin: rd_mux = uvin_warn_ff;
      hit_ocin: rd_mux = ocin_warn_ff;
      hit_pgon: rd_mux = pg_on_ff;
      hit_pgoff: rd_mux = pg_off_ff;
      hit_ton: rd_mux = ton_wait_ff;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 16'h0000;
      cml_fault_ff <= 1'b0;
    end else if (ce) begin
      rsp_valid_ff <= do_read;
      rsp_rdata_ff <= do_read ? rd_mux : 16'h0000;
      cml_fault_ff <= nxt_cml;
    end
  end

  // =====================================================================
  // scaled values of limits and measurements
  logic signed [ifp_pkg::FIX_W-1:0] scaled [4];
  wire logic [15:0] scale_in [4];

  assign scale_in[0] = vin_meas;
  assign scale_in[1] = uvin_warn_ff;
  assign scale_in[2] = iin_meas;
  assign scale_in[3] = ocin_warn_ff;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_scale
      ifp_lin11_scale u_scale (
        .word(scale_in[i]),
        .value(scaled[i])
      );
    end
  endgenerate

  wire logic nxt_vin_low = (scaled[0] <= scaled[1]);
  wire logic nxt_iin_oc = (scaled[2] >= scaled[3]);

  // =====================================================================
  // power-good with hysteresis
  wire logic pg_rise = (vout_meas >= pg_on_ff);
  wire logic pg_fall = (vout_meas <= pg_off_ff);
  // on threshold wins if the two are programmed crossed
  wire logic nxt_pgood = pg_rise | (pgood_ff & ~pg_fall);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vin_low_ff <= 1'b0;
    end else if (ce) begin
      vin_low_ff <= nxt_vin_low;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      iin_oc_ff <= 1'b0;
    end else if (ce) begin
      iin_oc_ff <= nxt_iin_oc;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pgood_ff <= 1'b0;
    end else if (ce) begin
      pgood_ff <= nxt_pgood;
    end
  end

  // =====================================================================
  // input overvoltage response
  wire logic [1:0] resp_bits = ovin_resp_ff[ifp_pkg::RSP_MSB:ifp_pkg::RSP_LSB];
  wire logic [2:0] retry_bits = ovin_resp_ff[ifp_pkg::RTY_MSB:ifp_pkg::RTY_LSB];
  wire logic [2:0] delay_bits = ovin_resp_ff[ifp_pkg::DLY_MSB:ifp_pkg::DLY_LSB];
  wire logic is_vendor = (ovin_resp_ff == ifp_pkg::OVIN_VENDOR_CODE);
  // restart only for response 11 with non-zero retry; delay bits do not gate it
  wire logic auto_restart = (resp_bits == ifp_pkg::RSP_OFF_WHILE) && (retry_bits != 3'h0)
    && !is_vendor;
  wire logic trips = (resp_bits != ifp_pkg::RSP_CONTINUE);

  always_comb begin
    nxt_ov_state = ov_state_ff;
    unique case (ov_state_ff)
      ifp_pkg::OV_RUN: begin
        if (ovin_detect && trips) begin
          nxt_ov_state = auto_restart ? ifp_pkg::OV_HOLD : ifp_pkg::OV_LATCH;
        end
      end
      ifp_pkg::OV_HOLD: begin
        if (!ovin_detect) begin
          nxt_ov_state = ifp_pkg::OV_RUN;
        end
      end
      ifp_pkg::OV_LATCH: begin
        // a fault still present outweighs the clear
        if (clear_faults && !ovin_detect) begin
          nxt_ov_state = ifp_pkg::OV_RUN;
        end
      end
      default: nxt_ov_state = ifp_pkg::OV_LATCH;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ov_state_ff <= ifp_pkg::OV_RUN;
    end else if (ce) begin
      ov_state_ff <= nxt_ov_state;
    end
  end

  wire logic ov_block = (nxt_ov_state != ifp_pkg::OV_RUN);
  wire logic nxt_latched = (nxt_ov_state == ifp_pkg::OV_LATCH);

  // =====================================================================
  // turn-on wait then enable
  wire logic ton_done;

  ifp_ton_timer #(
    .STEP_CYC(TON_STEP_CYC)
  ) u_ton (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .start(start_request),
    .delay_ms(ton_wait_ff[6:0]),
    .done(ton_done)
  );

  wire logic nxt_enable = ton_done & start_request & ~ov_block;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_enable_ff <= 1'b0;
    end else if (ce) begin
      out_enable_ff <= nxt_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ovin_off_ff <= 1'b0;
      ovin_latched_ff <= 1'b0;
      vendor_dev_ff <= 1'b0;
    end else if (ce) begin
      ovin_off_ff <= ov_block;
      ovin_latched_ff <= nxt_latched;
      vendor_dev_ff <= is_vendor;
    end
  end

  // =====================================================================
  // outputs
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign cml_fault = cml_fault_ff;
  assign vin_low_warn = vin_low_ff;
  assign iin_oc_warn = iin_oc_ff;
  assign pgood = pgood_ff;
  assign out_enable = out_enable_ff;
  assign ovin_off = ovin_off_ff;
  assign ovin_latched = ovin_latched_ff;
  assign vendor_deviation = vendor_dev_ff;

endmodule

// ==== bench/ifp_regs_props.sv ====
/*
  Checker for the command bank: ports only, two threshold shadows.
  Assumes it is bound to ifp_regs, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module ifp_regs_props #(
  parameter int TON_STEP_CYC = ifp_pkg::TON_STEP_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] vout_meas,
  input wire logic ovin_detect,
  input wire logic clear_faults,
  input wire logic start_request,
  input wire logic rsp_valid,
  input wire logic cml_fault,
  input wire logic pgood,
  input wire logic out_enable,
  input wire logic ovin_off,
  input wire logic ovin_latched,
  input wire logic vendor_deviation
);
  // ====================================================================
  // threshold shadows
  wire logic wr = cmd_valid && cmd_write && ce;
  logic [15:0] on_ff;
  logic [15:0] off_ff;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      on_ff <= 16'h0114;
      off_ff <= 16'h0105;
    end else begin
      if (wr && cmd_code == 8'h5e) on_ff <= cmd_wdata;
      if (wr && cmd_code == 8'h5f) off_ff <= cmd_wdata;
    end
  end
  wire logic bad58 = wr && cmd_code == 8'h58 && (cmd_wdata[15:11] != 5'h1f ||
    cmd_wdata[10:0] < 11'h002 || cmd_wdata[10:0] > 11'h0a0);

  // ====================================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rsp; cmd_valid && ce && !cmd_write |=> rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("read not answered");
  property p_cml58; bad58 |=> cml_fault; endproperty
  a_cml58: assert property (p_cml58) else $error("bad limit write not flagged");
  property p_ok60; wr && cmd_code == 8'h60 && cmd_wdata[15:7] == 9'h000 |=> !cml_fault; endproperty
  a_ok60: assert property (p_ok60) else $error("legal wait write flagged");
  property p_vend; wr && cmd_code == 8'h56 |-> ##2 vendor_deviation == ($past(cmd_wdata[7:0], 2) == 8'hb8);
  endproperty
  a_vend: assert property (p_vend) else $error("vendor flag wrong");
  property p_latch; ovin_latched && !clear_faults |=> ovin_latched; endproperty
  a_latch: assert property (p_latch) else $error("latch lost without clear");
  property p_clr; ovin_latched && clear_faults && !ovin_detect |=> !ovin_latched; endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
  property p_ovb8; vendor_deviation && ovin_detect && !cmd_valid && !$past(cmd_valid) |=> ovin_off; endproperty
  a_ovb8: assert property (p_ovb8) else $error("output not held off");
  property p_pgon; vout_meas >= on_ff |=> pgood; endproperty
  a_pgon: assert property (p_pgon) else $error("power good not asserted");
  property p_pgoff; vout_meas <= off_ff && vout_meas < on_ff |=> !pgood; endproperty
  a_pgoff: assert property (p_pgoff) else $error("power good not negated");
  property p_pghold; vout_meas > off_ff && vout_meas < on_ff |=> $stable(pgood); endproperty
  a_pghold: assert property (p_pghold) else $error("power good moved inside band");
  property p_endrop; !start_request |=> !out_enable; endproperty
  a_endrop: assert property (p_endrop) else $error("output enabled without start");
endmodule

bind ifp_regs ifp_regs_props #(.TON_STEP_CYC(TON_STEP_CYC)) i_props (.clock(clock), .rst_n(rst_n), .ce(ce),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
  .vout_meas(vout_meas), .ovin_detect(ovin_detect), .clear_faults(clear_faults),
  .start_request(start_request), .rsp_valid(rsp_valid), .cml_fault(cml_fault), .pgood(pgood),
  .out_enable(out_enable), .ovin_off(ovin_off), .ovin_latched(ovin_latched),
  .vendor_deviation(vendor_deviation));

// ==== bench/ifp_host_model.sv ====
/*
  Bus host model: issues one read or write command at a time.
  Assumes the bank answers in the cycle after the taking edge.
*/
`timescale 1ns/1ps
module ifp_host_model (
  input wire logic clock,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic cml_fault,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // read data only counts when the answer strobe agrees
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
    output logic [15:0] rd, output logic flt);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wd;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~wd;
    rd = (rsp_valid === !wr) ? rsp_rdata : 16'hxxxx;
    flt = cml_fault;
  endtask
endmodule

// ==== bench/input_fault_pgood_cmd_regs_tb_top.sv ====
/*
  Self-checking bench for the command bank, random data with corner cases.
  Assumes a 200 MHz clock and a shortened millisecond of 4 cycles.
*/
`timescale 1ns/1ps
module input_fault_pgood_cmd_regs_tb_top;
  localparam int STEP = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_write, rsp_valid, cml_fault, vin_low_warn, iin_oc_warn, pgood;
  logic out_enable, ovin_off, ovin_latched, vendor_deviation, f, ep;
  logic ce = 1'b1;
  logic ovin_detect = 1'b0;
  logic clear_faults = 1'b0;
  logic start_request = 1'b0;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata, rd;
  logic [15:0] vin_meas = 16'h0000;
  logic [15:0] iin_meas = 16'h0000;
  logic [15:0] vout_meas = 16'h0000;
  logic [7:0] codes [6] = '{8'h56, 8'h58, 8'h5d, 8'h5e, 8'h5f, 8'h60};
  logic [15:0] mdl [6] = '{16'h00b8, 16'hf812, 16'hf80a, 16'h0114, 16'h0105, 16'h0000};
  logic [19:0] cv [12] = '{20'h1f802, 20'h1f8a0, 20'h1f801, 20'h1f8a1, 20'h10812, 20'h2f8fe,
    20'h2f8ff, 20'h2f800, 20'h5007f, 20'h50080, 20'h5f805, 20'h3ffff};
  logic [7:0] ov [9] = '{8'h00, 8'h16, 8'h22, 8'h36, 8'hc0, 8'hd6, 8'he2, 8'hf6, 8'hb8};
  int miscompares = 0;
  int samples_checked = 0;
  int n;

  always #2.5 clock = ~clock;

  ifp_regs #(.TON_STEP_CYC(STEP)) i_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .vin_meas(vin_meas),
    .iin_meas(iin_meas), .vout_meas(vout_meas), .ovin_detect(ovin_detect), .clear_faults(clear_faults),
    .start_request(start_request), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cml_fault(cml_fault),
    .vin_low_warn(vin_low_warn), .iin_oc_warn(iin_oc_warn), .pgood(pgood), .out_enable(out_enable),
    .ovin_off(ovin_off), .ovin_latched(ovin_latched), .vendor_deviation(vendor_deviation));
  ifp_host_model i_host (.clock(clock), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cml_fault(cml_fault),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  // ====================================================================
  // expectation helpers
  function automatic logic ok_wr(input logic [7:0] c, input logic [15:0] w);
    case (c)
      8'h58: return w[15:11] == 5'h1f && w[10:0] >= 11'h002 && w[10:0] <= 11'h0a0;
      8'h5d: return w[15:11] == 5'h1f && w[10:0] <= 11'h0fe;
      8'h60: return w[15:7] == 9'h000;
      default: return 1'b1;
    endcase
  endfunction
  function automatic real lval(input logic [15:0] w);
    return $itor($signed(w[10:0])) * (2.0 ** $signed(w[15:11]));
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic rd_chk(input int i);
    i_host.xfer(1'b0, codes[i], 16'h0000, rd, f);
    chk(rd, mdl[i], "read back");
    chk({15'h0, f}, 16'h0000, "read fault");
  endtask
  task automatic wr(input int i, input logic [15:0] w);
    logic ok;
    ok = ok_wr(codes[i], w);
    i_host.xfer(1'b1, codes[i], w, rd, f);
    chk({15'h0, f}, {15'h0, !ok}, "write fault");
    if (ok) mdl[i] = (i == 0) ? {8'h00, w[7:0]} : w;
    rd_chk(i);
  endtask
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ====================================================================
  // tests
  initial begin
    void'($urandom(40227));
    cyc(5);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(i);
    chk({15'h0, vendor_deviation}, 16'h0001, "vendor flag");
    $display("test reset values done");
    foreach (cv[k]) wr(int'(cv[k][19:16]), cv[k][15:0]);
    repeat (40) begin
      n = $urandom_range(0, 5);
      if (n == 0 || n == 3 || n == 4) wr(n, 16'($urandom));
      else wr(n, {($urandom_range(0, 7) == 0) ? 5'($urandom) : (n == 5 ? 5'h00 : 5'h1f),
        11'($urandom_range(0, 300))});
    end
    i_host.xfer(1'b0, 8'h57, 16'h0000, rd, f);
    chk({f, rd[14:0]}, 16'h8000, "unknown read");
    // a write while frozen must not land
    cyc(1);
    ce = 1'b0;
    i_host.xfer(1'b1, codes[1], (mdl[1] == 16'hf814) ? 16'hf816 : 16'hf814, rd, f);
    ce = 1'b1;
    chk({15'h0, f}, 16'h0000, "frozen write");
    rd_chk(1);
    $display("test register access done");
    repeat (30) begin
      vin_meas = {5'h1e + 5'($urandom_range(0, 2)), 11'($urandom_range(0, 200))};
      iin_meas = {5'h1e + 5'($urandom_range(0, 2)), 11'($urandom_range(0, 300))};
      cyc(2);
      chk({15'h0, vin_low_warn}, {15'h0, lval(vin_meas) <= lval(mdl[1])}, "low input warn");
      chk({15'h0, iin_oc_warn}, {15'h0, lval(iin_meas) >= lval(mdl[2])}, "overcurrent warn");
    end
    $display("test warnings done");
    wr(3, 16'h0114);
    wr(4, 16'h0105);
    cyc(2);
    ep = 1'b0;
    repeat (40) begin
      vout_meas = 16'h00f8 + 16'($urandom_range(0, 64));
      ep = (vout_meas >= mdl[3]) ? 1'b1 : (vout_meas <= mdl[4]) ? 1'b0 : ep;
      cyc(2);
      chk({15'h0, pgood}, {15'h0, ep}, "power good");
    end
    $display("test power good done");
    wr(5, 16'h0000);
    start_request = 1'b1;
    foreach (ov[k]) begin
      wr(0, {8'h00, ov[k]});
      clear_faults = 1'b1;
      cyc(1);
      clear_faults = 1'b0;
      cyc(3);
      chk({15'h0, vendor_deviation}, {15'h0, ov[k] == 8'hb8}, "vendor flag");
      ovin_detect = 1'b1;
      cyc(3);
      ep = ov[k][7:6] == 2'h3 || ov[k] == 8'hb8;
      chk({13'h0, ovin_latched, ovin_off, out_enable}, {13'h0, (ov[k] == 8'hc0 || ov[k] == 8'hb8), ep, !ep},
        "off during fault");
      ovin_detect = 1'b0;
      cyc(3);
      ep = ov[k] == 8'hc0 || ov[k] == 8'hb8;
      chk({13'h0, ovin_latched, ovin_off, out_enable}, {13'h0, ep, ep, !ep}, "after fault");
      clear_faults = 1'b1;
      cyc(1);
      clear_faults = 1'b0;
      cyc(3);
      chk({13'h0, ovin_latched, ovin_off, out_enable}, 16'h0001, "after clear");
    end
    $display("test overvoltage response done");
    foreach (cv[k]) if (k < 3) begin
      n = 0;
      start_request = 1'b0;
      wr(5, 16'(k * 3 + (k == 2) * 121));
      chk({15'h0, out_enable}, 16'h0000, "enable without start");
      start_request = 1'b1;
      while (out_enable !== 1'b1 && n < 1000) begin
        cyc(1);
        n++;
      end
      chk(16'(n >= mdl[5] * STEP + 2 && n <= mdl[5] * STEP + 4), 16'h0001, "turn-on wait");
    end
    $display("test turn-on wait done");
    test_done();
  end

  initial begin
    #200000;
    miscompares++;
    $display("MISMATCH %0t watchdog expired", $time);
    test_done();
  end
endmodule
